//--- core/epwm_mem.sv
// cpu-side memory subsystem: rom port, ram, paged nonvolatile array,
// page-move engine and an avalon-mm control slave
// assumes the cpu holds each request until it is acknowledged
//
// Added by the designer: the register addresses and the Avalon-MM slave port.
`timescale 1ns/100ps
// Contract
// [RULE1] the nonvolatile array is 256 pages of 32 bytes, written only a page at a time.
// [RULE2] a page move, set up by three cpu registers, copies 32 ram bytes into one page; the code copies only pm_len_i+1 bytes.
// [RULE3] an on-chip timer drives the high-voltage phase so one page write takes about 10 ms.
// [RULE4] a readable status bit tells whether the supply dipped during the write interval.
// [RULE5] control bits choose erase or overwrite instead of the normal write.
// [RULE6] a control bit, when set, disables the page move so no page is written.
// [RULE7] with the protect bit set, an overwrite of a page records it in the protect area.
// [RULE8] nonvolatile reads follow the rom sequence but return a single byte.
// [RULE9] rom is read over a 16-bit path, two bytes per access, in two cycles.
// [RULE10] ram is 16-bit words, two-cycle access, usable for fetches and data.
// [RULE11] rom, nonvolatile memory and ram share one 64k map, sized 10k, 8k and 256 bytes.
// [RULE12] a further 2k of rom beyond the program area is reserved for test only.
// [RULE13] short 8-bit absolute addresses reach only the top page, 16-bit ones all of it.
// [RULE14] while a page write runs the move is held and no other write starts until the timer ends.
module epwm_mem #(
  parameter int WRITE_CYC = epwm_pkg::WRITE_CYC, // page write length
  parameter int TMR_W = 21 // timer width
) (
  input wire logic sys_clk_i, // system clock
  input wire logic rst_i, // sync reset, active high
  input wire logic mem_req_i, // cpu memory request
  input wire logic mem_we_i, // 1 = write
  input wire logic mem_short_i, // 8-bit absolute address
  input wire logic [15:0] mem_addr_i, // byte address
  input wire logic [15:0] mem_wdata_i, // write word
  output logic mem_ack_o, // access complete
  output logic [15:0] mem_rdata_o, // read word
  output logic [12:0] rom_addr_o, // rom word address
  input wire logic [15:0] rom_data_i, // rom word
  input wire logic pm_req_i, // page move request
  input wire logic [7:0] pm_src_i, // ram source byte
  input wire logic [7:0] pm_page_i, // destination page
  input wire logic [4:0] pm_len_i, // byte count minus one
  output logic pm_ack_o, // page move finished
  input wire logic supply_low_i, // supply dip detect
  output logic hv_en_o, // high-voltage enable
  input wire logic [4:0] avs_address_i, // byte address
  input wire logic avs_read_i, // read strobe
  input wire logic avs_write_i, // write strobe
  input wire logic [31:0] avs_writedata_i, // write data
  input wire logic [3:0] avs_byteenable_i, // byte lanes
  output logic [31:0] avs_readdata_o, // read data
  output logic avs_waitrequest_o, // stall
  output logic irq_o // interrupt, active high
);
  import epwm_pkg::*;

  // ****************************************
  // storage
  // ****************************************
  logic [15:0] ram_mem [RAM_WORDS];
  logic [7:0] nv_mem [NV_BYTES];
  logic [NV_PAGES-1:0] prot_map_reg;

  // ****************************************
  // registers
  // ****************************************
  logic ctl_dis_reg;
  epwm_mode_t ctl_mode_reg;
  logic prot_en_reg;
  logic [EV_W-1:0] sts_reg;
  logic [EV_W-1:0] mask_reg;
  logic acc_reg;
  logic [31:0] rdata_reg;
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] w1c;
  logic reg_wr;

  // ****************************************
  // cpu access path
  // ****************************************
  logic [15:0] eff_addr;
  logic ph_reg;
  logic [15:0] mdata_reg;
  logic in_rom;
  logic in_nv;
  logic in_ram;
  // short addresses are forced into the top page [RULE13]
  assign eff_addr = mem_short_i ? {TOP_PAGE, mem_addr_i[7:0]} : mem_addr_i;
  // [RULE11] map decode; the test area above rom reads zero [RULE12]
  assign in_rom = eff_addr <= ROM_TOP;
  assign in_nv = eff_addr >= NV_BASE && eff_addr <= NV_TOP;
  assign in_ram = eff_addr[15:8] == TOP_PAGE;
  assign rom_addr_o = eff_addr[13:1];
  assign mem_ack_o = ph_reg;
  assign mem_rdata_o = mdata_reg;

  // two-cycle access: request seen, then answer [RULE9] [RULE10]
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ph_reg <= 1'b0;
    end else begin
      ph_reg <= mem_req_i & ~ph_reg;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      mdata_reg <= 16'h0000;
    end else if (mem_req_i && !ph_reg) begin
      if (mem_we_i) begin
        mdata_reg <= 16'h0000;
      end else if (in_rom) begin
        mdata_reg <= rom_data_i; // [RULE9]
      end else if (in_nv) begin
        mdata_reg <= {8'h00, nv_mem[eff_addr[12:0]]}; // [RULE8]
      end else if (in_ram) begin
        mdata_reg <= ram_mem[eff_addr[7:1]]; // [RULE10]
      end else begin
        mdata_reg <= 16'h0000; // [RULE12]
      end
    end
  end

  // ram takes cpu word writes; the array is never cpu-writable
  always_ff @(posedge sys_clk_i) begin
    if (mem_req_i && !ph_reg && mem_we_i && in_ram) begin
      ram_mem[eff_addr[7:1]] <= mem_wdata_i; // [RULE10]
    end
  end

  // ****************************************
  // page move engine
  // ****************************************
  epwm_state_t st_reg;
  logic [TMR_W-1:0] tmr_reg;
  logic [4:0] cnt_reg;
  logic [4:0] len_reg;
  logic [7:0] src_reg;
  logic [7:0] page_reg;
  epwm_mode_t mode_reg;
  logic refused_reg;
  logic [7:0] src_byte_addr;
  logic [15:0] src_word;
  logic [7:0] src_byte;
  logic [12:0] nv_idx;
  logic start;
  logic refuse;

  // disabled engine or protected page turns the move away [RULE6] [RULE7]
  assign start = st_reg == EPWM_IDLE && pm_req_i;
  assign refuse = ctl_dis_reg || prot_map_reg[pm_page_i];
  assign src_byte_addr = src_reg + {3'b000, cnt_reg};
  assign src_word = ram_mem[src_byte_addr[7:1]];
  // even byte sits in the high half, as the cpu orders words
  assign src_byte = src_byte_addr[0] ? src_word[7:0] : src_word[15:8];
  assign nv_idx = {page_reg, cnt_reg}; // [RULE1]
  assign pm_ack_o = st_reg == EPWM_DONE;
  assign hv_en_o = st_reg == EPWM_COPY || st_reg == EPWM_TIME; // [RULE3]

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st_reg <= EPWM_IDLE;
      tmr_reg <= '0;
      cnt_reg <= 5'h00;
      len_reg <= 5'h00;
      src_reg <= 8'h00;
      page_reg <= 8'h00;
      mode_reg <= EPWM_NORMAL;
      refused_reg <= 1'b0;
    end else begin
      case (st_reg)
        EPWM_IDLE: begin
          if (start) begin
            src_reg <= pm_src_i; // [RULE2]
            page_reg <= pm_page_i;
            len_reg <= pm_len_i;
            mode_reg <= ctl_mode_reg;
            cnt_reg <= 5'h00;
            refused_reg <= refuse;
            tmr_reg <= TMR_W'(WRITE_CYC - 1); // [RULE3]
            st_reg <= refuse ? EPWM_DONE : EPWM_COPY; // [RULE6]
          end
        end
        EPWM_COPY: begin
          tmr_reg <= tmr_reg - 1'b1;
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == 5'(PAGE_BYTES - 1)) begin
            st_reg <= EPWM_TIME; // [RULE2]
          end
        end
        EPWM_TIME: begin
          // the move stays held until the timer runs out [RULE14]
          if (tmr_reg == '0) begin
            st_reg <= EPWM_DONE;
          end else begin
            tmr_reg <= tmr_reg - 1'b1;
          end
        end
        EPWM_DONE: begin
          st_reg <= EPWM_IDLE;
        end
        default: begin
          st_reg <= EPWM_IDLE;
        end
      endcase
    end
  end

  // whole page is touched; bytes past the count are erased, but kept in overwrite mode [RULE1]
  always_ff @(posedge sys_clk_i) begin
    if (st_reg == EPWM_COPY) begin
      case (mode_reg)
        EPWM_ERASE: begin
          nv_mem[nv_idx] <= ERASED; // [RULE5]
        end
        EPWM_OVERWR: begin
          if (cnt_reg <= len_reg) begin
            nv_mem[nv_idx] <= nv_mem[nv_idx] & src_byte; // [RULE5]
          end
        end
        default: begin
          nv_mem[nv_idx] <= (cnt_reg <= len_reg) ? src_byte : ERASED;
        end
      endcase
    end
  end
  // protect area: overwrite with protect bit set records the page
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      prot_map_reg <= '0;
    end else if (start && !refuse && prot_en_reg &&
                 ctl_mode_reg == EPWM_OVERWR) begin
      prot_map_reg[pm_page_i] <= 1'b1; // [RULE7]
    end
  end

  // ****************************************
  // avalon slave and interrupt
  // ****************************************
  // one wait state per access; read data is ready when wait drops
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~acc_reg;
  assign avs_readdata_o = rdata_reg;
  assign reg_wr = avs_write_i && acc_reg && avs_byteenable_i[0];
  assign ev_set[ST_DONE] = st_reg == EPWM_DONE && !refused_reg;
  assign ev_set[ST_REFUSE] = st_reg == EPWM_DONE && refused_reg;
  assign ev_set[ST_FLUCT] = hv_en_o && supply_low_i; // [RULE4]
  assign w1c = (reg_wr && avs_address_i == OFS_STATUS) ?
               avs_writedata_i[EV_W-1:0] : '0;
  assign irq_o = |(sts_reg & mask_reg);
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      acc_reg <= 1'b0;
    end else begin
      acc_reg <= (avs_read_i | avs_write_i) & ~acc_reg;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (avs_read_i && !acc_reg) begin
      case (avs_address_i)
        OFS_CTRL: rdata_reg <= {29'h0, ctl_mode_reg, ctl_dis_reg};
        OFS_STATUS: rdata_reg <= {28'h0, hv_en_o, sts_reg}; // [RULE4]
        OFS_MASK: rdata_reg <= {29'h0, mask_reg};
        OFS_PROT: rdata_reg <= {31'h0, prot_en_reg};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ctl_dis_reg <= 1'b0;
      ctl_mode_reg <= EPWM_NORMAL;
      mask_reg <= '0;
      prot_en_reg <= 1'b0;
    end else if (reg_wr) begin
      case (avs_address_i)
        OFS_CTRL: begin
          ctl_dis_reg <= avs_writedata_i[CTRL_DIS]; // [RULE6]
          ctl_mode_reg <= epwm_mode_t'(avs_writedata_i[CTRL_MODE_LO +: 2]);
        end
        OFS_MASK: mask_reg <= avs_writedata_i[EV_W-1:0];
        OFS_PROT: prot_en_reg <= avs_writedata_i[PROT_EN]; // [RULE7]
        default: begin
        end
      endcase
    end
  end
  // a new event wins over a clear in the same cycle
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sts_reg <= '0;
    end else begin
      sts_reg <= (sts_reg & ~w1c) | ev_set; // [RULE4]
    end
  end

  // ****************************************
  // checks
  // ****************************************
  logic [TMR_W-1:0] busy_cnt;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || st_reg == EPWM_IDLE) begin
      busy_cnt <= '0;
    end else if (hv_en_o) begin
      busy_cnt <= busy_cnt + 1'b1;
    end
  end

  mem_two_cyc_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE9]
    mem_req_i && !ph_reg |=> mem_ack_o ##1 !mem_ack_o)
    else $error("access not answered in two cycles");
  nv_byte_rd_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE8]
    mem_req_i && !ph_reg && !mem_we_i && in_nv |=> mem_rdata_o[15:8] == 8'h00)
    else $error("nonvolatile read not byte wide");
  short_top_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE13]
    mem_short_i |-> in_ram)
    else $error("short address left the top page");
  test_rom_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE12]
    mem_req_i && !ph_reg && eff_addr > ROM_TOP && eff_addr <= TROM_TOP
    |=> mem_rdata_o == 16'h0000)
    else $error("test rom visible");
  copy_len_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE2]
    st_reg == EPWM_COPY ##1 st_reg == EPWM_TIME |->
    busy_cnt == TMR_W'(PAGE_BYTES))
    else $error("copy phase not 32 cycles");
  write_time_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE3]
    st_reg == EPWM_DONE && !refused_reg |-> busy_cnt == TMR_W'(WRITE_CYC))
    else $error("page write length wrong");
  disabled_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE6]
    start && ctl_dis_reg |=> st_reg == EPWM_DONE ##1 st_reg == EPWM_IDLE)
    else $error("move ran while disabled");
  held_busy_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE14]
    st_reg == EPWM_TIME && tmr_reg != '0 |=> st_reg == EPWM_TIME && !pm_ack_o)
    else $error("move released before timer end");
  fluct_flag_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE4]
    hv_en_o && supply_low_i |=> sts_reg[ST_FLUCT])
    else $error("supply dip not flagged");
  prot_rec_a: assert property (@(posedge sys_clk_i) disable iff (rst_i) // [RULE7]
    start && !refuse && prot_en_reg && ctl_mode_reg == EPWM_OVERWR
    |=> prot_map_reg[page_reg])
    else $error("protected page not recorded");
endmodule

//--- core/epwm_pkg.sv
// constants for the paged nonvolatile memory subsystem
// assumes a 125 MHz system clock and a cpu with a 16-bit data path
package epwm_pkg;
  // ****************************************
  // address map
  // ****************************************
  localparam logic [15:0] ROM_TOP = 16'h27ff;
  localparam logic [15:0] TROM_TOP = 16'h2fff;
  localparam logic [15:0] NV_BASE = 16'h4000;
  localparam logic [15:0] NV_TOP = 16'h5fff;
  localparam logic [7:0] TOP_PAGE = 8'hff;
  localparam int ROM_WORDS = 5120;
  localparam int RAM_WORDS = 128;
  localparam int NV_PAGES = 256;
  localparam int PAGE_BYTES = 32;
  localparam int NV_BYTES = NV_PAGES * PAGE_BYTES;
  // ****************************************
  // write timing
  // ****************************************
  localparam int WRITE_TIME_US = 10000;
  localparam int CLK_MHZ = 125;
  localparam int WRITE_CYC = WRITE_TIME_US * CLK_MHZ;
  // ****************************************
  // register offsets and fields
  // ****************************************
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_STATUS = 5'h04;
  localparam logic [4:0] OFS_MASK = 5'h08;
  localparam logic [4:0] OFS_PROT = 5'h0c;
  localparam int CTRL_DIS = 0;
  localparam int CTRL_MODE_LO = 1;
  localparam int ST_DONE = 0;
  localparam int ST_FLUCT = 1;
  localparam int ST_REFUSE = 2;
  localparam int ST_BUSY = 3;
  localparam int EV_W = 3;
  localparam int PROT_EN = 0;
  localparam logic [7:0] ERASED = 8'hff;
  typedef enum logic [1:0] {
    EPWM_NORMAL = 2'b00,
    EPWM_ERASE = 2'b01,
    EPWM_OVERWR = 2'b10
  } epwm_mode_t;
  typedef enum logic [1:0] {
    EPWM_IDLE = 2'b00,
    EPWM_COPY = 2'b01,
    EPWM_TIME = 2'b10,
    EPWM_DONE = 2'b11
  } epwm_state_t;
endpackage

//--- dv/epwm_cpu_model.sv
// cpu model: drives the memory port and the page-move port
// assumes the bench waits out reset before calling its tasks
`timescale 1ns/100ps
module epwm_cpu_model (
  input wire logic clk_i, // system clock
  input wire logic mem_ack_i, // access done
  input wire logic [15:0] mem_rdata_i, // read word
  input wire logic pm_ack_i, // move done
  output logic mem_req_o = 1'b0, // access request
  output logic mem_we_o = 1'b0, // write
  output logic mem_short_o = 1'b0, // 8-bit address
  output logic [15:0] mem_addr_o = 16'h0000, // byte address
  output logic [15:0] mem_wdata_o = 16'h0000, // write word
  output logic pm_req_o = 1'b0, // move request
  output logic [7:0] pm_src_o = 8'h00, // ram source
  output logic [7:0] pm_page_o = 8'h00, // page
  output logic [4:0] pm_len_o = 5'h00 // count minus one
);
  // ****************************************
  // requests are held until acknowledged
  // ****************************************
  task automatic access(input logic we, input logic sh,
      input logic [15:0] a, input logic [15:0] wd,
      output logic [15:0] rd);
    int n;
    n = 0;
    mem_we_o <= we;
    mem_short_o <= sh;
    mem_addr_o <= a;
    mem_wdata_o <= wd;
    mem_req_o <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (mem_ack_i !== 1'b1 && n < 50);
    rd = mem_rdata_i;
    mem_req_o <= 1'b0;
    @(posedge clk_i);
  endtask
  // three set-up values stand for the cpu's general registers
  task automatic page_move(input logic [7:0] s, input logic [7:0] p,
      input logic [4:0] l, output int n);
    n = 0;
    pm_src_o <= s;
    pm_page_o <= p;
    pm_len_o <= l;
    pm_req_o <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pm_ack_i !== 1'b1 && n < 5000);
    pm_req_o <= 1'b0;
    @(posedge clk_i);
    n = n - 1;
  endtask
endmodule

//--- dv/epwm_mem_tb_top.sv
// bench: cpu model, rom stub, avalon master and a byte-level
// reference of ram and the nonvolatile array
// assumes a short page-write timer so moves end quickly
`timescale 1ns/100ps
module epwm_mem_tb_top;
  import epwm_pkg::*;
  localparam int WC = 64;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic supply_low_i = 1'b0;
  logic [4:0] avs_address_i = 5'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'hf;
  logic [31:0] avs_readdata_o, rv;
  logic avs_waitrequest_o, irq_o, hv_en_o, mem_ack_o, pm_ack_o;
  logic mem_req_i, mem_we_i, mem_short_i, pm_req_i;
  logic [15:0] mem_addr_i, mem_wdata_i, mem_rdata_o, rom_data_i, d, a;
  logic [12:0] rom_addr_o;
  logic [7:0] pm_src_i, pm_page_i;
  logic [4:0] pm_len_i;
  logic [7:0] ram_b [256];
  logic [7:0] nv_m [8192];
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  int lat;
  always #4 sys_clk_i = ~sys_clk_i;
  // rom stub: each word is derived from its own address
  assign rom_data_i = {3'h5, rom_addr_o};
  epwm_mem #(.WRITE_CYC(WC)) uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .mem_req_i(mem_req_i), .mem_we_i(mem_we_i),
    .mem_short_i(mem_short_i), .mem_addr_i(mem_addr_i),
    .mem_wdata_i(mem_wdata_i), .mem_ack_o(mem_ack_o),
    .mem_rdata_o(mem_rdata_o), .rom_addr_o(rom_addr_o),
    .rom_data_i(rom_data_i), .pm_req_i(pm_req_i), .pm_src_i(pm_src_i),
    .pm_page_i(pm_page_i), .pm_len_i(pm_len_i), .pm_ack_o(pm_ack_o),
    .supply_low_i(supply_low_i), .hv_en_o(hv_en_o),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o));
  epwm_cpu_model cpu (.clk_i(sys_clk_i), .mem_ack_i(mem_ack_o),
    .mem_rdata_i(mem_rdata_o), .pm_ack_i(pm_ack_o), .mem_req_o(mem_req_i),
    .mem_we_o(mem_we_i), .mem_short_o(mem_short_i),
    .mem_addr_o(mem_addr_i), .mem_wdata_o(mem_wdata_i),
    .pm_req_o(pm_req_i), .pm_src_o(pm_src_i), .pm_page_o(pm_page_i),
    .pm_len_o(pm_len_i));
  // ****************************************
  // compares, bus cycles and reference updates
  // ****************************************
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %0t data %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_cyc(input int got, input int exp);
    n_compared++;
    if (got != exp) begin
      error_cnt++;
      $display("FAIL %0t latency %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic av(input logic wr, input logic [4:0] ad,
      input logic [31:0] wd);
    int n;
    n = 0;
    avs_address_i <= ad;
    avs_writedata_i <= wd;
    avs_read_i <= ~wr;
    avs_write_i <= wr;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    rv = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  task automatic mv(input int p, input int len, input int mode,
      input logic dis, input logic acc);
    logic [7:0] s;
    int k;
    s = 8'($urandom);
    av(1'b1, OFS_CTRL, {29'h0, 2'(mode), dis});
    cpu.page_move(s, 8'(p), 5'(len), lat);
    chk_cyc(lat, acc ? WC + 1 : 1);
    for (int i = 0; i < PAGE_BYTES; i++) begin
      k = p * PAGE_BYTES + i;
      if (acc && mode == 1)
        nv_m[k] = ERASED;
      else if (acc && mode == 2 && i <= len)
        nv_m[k] = nv_m[k] & ram_b[8'(s + i)];
      else if (acc && mode != 2)
        nv_m[k] = i <= len ? ram_b[8'(s + i)] : ERASED;
      cpu.access(1'b0, 1'b0, NV_BASE + 16'(k), 16'h0, d);
      chk_word({16'h0, d}, {24'h0, nv_m[k]});
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      end_of_test();
    end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rv = $urandom(32'hacbe);
    repeat (6) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    for (int r = 0; r < 5; r++) begin
      av(1'b0, 5'(4 * r), 32'h0);
      chk_word(rv, 32'h0);
    end
    for (int w = 0; w < RAM_WORDS; w++) begin
      d = 16'($urandom);
      ram_b[2 * w] = d[15:8];
      ram_b[2 * w + 1] = d[7:0];
      a = {w[0] ? 8'($urandom) : 8'hff, 8'(2 * w)};
      cpu.access(1'b1, w[0], a, d, d);
    end
    for (int w = 0; w < RAM_WORDS; w++) begin
      cpu.access(1'b0, 1'b0, 16'hff01 + 16'(2 * w), 16'h0, d);
      chk_word({16'h0, d}, {16'h0, ram_b[2 * w], ram_b[2 * w + 1]});
    end
    for (int i = 0; i < 7; i++) begin
      a = i < 3 ? 16'($urandom) % 16'h2800 : i == 3 ? 16'h27fe :
          i == 4 ? 16'h2800 + 16'($urandom) % 16'h0800 :
          16'h2800 + 16'(i * 16'h1a00);
      cpu.access(1'b0, 1'b0, a, 16'h0, d);
      chk_word({16'h0, d}, a <= ROM_TOP ? {19'h5, a[13:1]} : 32'h0);
    end
    mv(0, 31, 0, 1'b0, 1'b1);
    mv(0, 31, 2, 1'b0, 1'b1);
    mv(255, 15, 0, 1'b0, 1'b1);
    mv(255, 31, 1, 1'b0, 1'b1);
    mv(0, 31, 0, 1'b1, 1'b0);
    av(1'b0, OFS_STATUS, 32'h0);
    chk_word(rv, 32'h5);
    av(1'b1, OFS_STATUS, 32'h7);
    av(1'b1, OFS_MASK, 32'h2);
    supply_low_i <= 1'b1;
    mv(1, 31, 0, 1'b0, 1'b1);
    supply_low_i <= 1'b0;
    av(1'b0, OFS_STATUS, 32'h0);
    chk_word(rv, 32'h3);
    chk_word({31'h0, irq_o}, 32'h1);
    av(1'b1, OFS_STATUS, 32'h7);
    chk_word({31'h0, irq_o}, 32'h0);
    av(1'b1, OFS_PROT, 32'h1);
    mv(2, 31, 3, 1'b0, 1'b1);
    mv(2, 31, 2, 1'b0, 1'b1);
    mv(2, 31, 0, 1'b0, 1'b0);
    av(1'b0, OFS_STATUS, 32'h0);
    chk_word(rv, 32'h5);
    end_of_test();
  end
endmodule
